// >>> src/can_mode_defines.svh
// timing counts and reset values for the can mode controller
`ifndef CAN_MODE_DEFINES_SVH
`define CAN_MODE_DEFINES_SVH
`define CLK_FREQ_HZ        25000000
`define BIT_TIME_NS        2000
`define BIT_CYCLES         ((`BIT_TIME_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
`define IDLE_BITS          11
`define BUSOFF_GROUPS      128
`define GLITCH_TIME_NS     480
`define GLITCH_CYCLES      ((`GLITCH_TIME_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
`define RECOVERY_TIME_NS   1000
`define RECOVERY_CYCLES    ((`RECOVERY_TIME_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
`define INIT_CAN_STAGES    3
`define RECESSIVE          1'b1
`endif

// >>> src/can_mode_pkg.sv
// types for the can mode controller
package can_mode_pkg;
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_SLEEP_PEND,
    MODE_SLEEP,
    MODE_INIT,
    MODE_POWER_DOWN,
    MODE_RECOVER
  } mode_e;

  typedef struct packed {
    logic       wake_irq_flag;
    logic       status_change_flag;
    logic       overrun_flag;
    logic       rx_full_flag;
    logic [2:0] tx_empty_flags;
  } irq_flags_s;

  typedef struct packed {
    logic       wake_irq_enable;
    logic       status_change_irq_enable;
    logic       overrun_irq_enable;
    logic       rx_full_irq_enable;
    logic [2:0] tx_empty_irq_enables;
  } irq_enables_s;

  typedef struct packed {
    logic wake;
    logic error;
    logic rx;
    logic tx;
  } irq_lines_s;
endpackage : can_mode_pkg

// >>> src/can_power_init_mode_ctrl.sv
// sleep, initialization and power-down mode controller of a can node
// Operation
// - sleep request clear ignored until sleep active
// - wait eleven recessive bits after wake-up
// - keep rx buffers, run deferred actions on wake
// - bus-off recovery count resumes after sleep
// - init aborts traffic, transmit pin recessive
// - init stops engine, resets control registers
// - config registers writable only in init
// - init request handshaked across clock domains
// - init acknowledge once all parts initialised
// - init request clear ignored until acknowledged
// - power-down on stop, or wait with stop_in_wait
// - power-down halts traffic, transmit pin recessive
// - power-down stops clocks, blocks register access
// - recovery delay after power-down without sleep
// - wake on bus activity when enabled
// - optional glitch filter on wake input
// - wake and error interrupts with enables
// - receive and transmit interrupts with enables
// - leave sleep only by activity, clear or init request
// - wake disabled masks receive input recessive in sleep
// - sleep entered after traffic finishes
`timescale 1ns/1ns
`default_nettype none
`include "can_mode_defines.svh"
module can_power_init_mode_ctrl (
  input  wire logic                     clock_in,
  input  wire logic                     rst_in,
  input  wire logic                     sleep_request_set_in,
  input  wire logic                     sleep_request_clr_in,
  input  wire logic                     init_request_set_in,
  input  wire logic                     init_request_clr_in,
  input  wire logic                     stop_in_wait_in,
  input  wire logic                     wake_enable_in,
  input  wire logic                     wake_filter_select_in,
  input  wire logic                     cpu_stop_in,
  input  wire logic                     cpu_wait_in,
  input  wire logic                     bus_rx_pin_in,
  input  wire logic                     engine_tx_in,
  input  wire logic                     tx_pending_in,
  input  wire logic                     rx_active_in,
  input  wire logic                     bus_off_in,
  input  wire logic                     config_write_in,
  input  wire can_mode_pkg::irq_flags_s   irq_flags_in,
  input  wire can_mode_pkg::irq_enables_s irq_enables_in,
  output logic                          sleep_request_out,
  output logic                          sleep_acknowledge_out,
  output logic                          init_request_out,
  output logic                          init_acknowledge_out,
  output logic                          bus_tx_pin_out,
  output logic                          engine_rx_out,
  output logic                          engine_run_out,
  output logic                          engine_abort_out,
  output logic                          synchronized_out,
  output logic                          regs_reset_out,
  output logic                          config_write_en_out,
  output logic                          reg_access_en_out,
  output logic                          clocks_on_out,
  output logic                          deferred_run_out,
  output logic                          busoff_count_run_out,
  output logic                          wake_event_out,
  output can_mode_pkg::irq_lines_s      irq_out
);

  // ==========================================================
  // pin input synchronisers
  logic [2:0] rx_sync_q;
  logic       rx_q;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_sync_q <= {3{`RECESSIVE}};
      rx_q      <= `RECESSIVE;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], bus_rx_pin_in};
      if (rx_sync_q[1] == rx_sync_q[2]) begin
        rx_q <= rx_sync_q[2];
      end
    end
  end

  // ==========================================================
  // request synchronisers into the can domain, acknowledge synchronisers back
  logic [1:0] sleep_sync_q;
  logic [`INIT_CAN_STAGES-1:0] init_sync_q;
  logic [1:0] sack_sync_q;
  logic [1:0] iack_sync_q;
  logic       sleep_request_q;
  logic       init_request_q;
  logic       sleep_core_q;
  logic       init_core_q;
  can_mode_pkg::mode_e mode_q;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sleep_sync_q <= 2'h0;
      init_sync_q  <= '1;
      sack_sync_q  <= 2'h0;
      iack_sync_q  <= 2'h3;
    end else begin
      sleep_sync_q <= {sleep_sync_q[0], sleep_request_q};
      init_sync_q  <= {init_sync_q[`INIT_CAN_STAGES-2:0], init_request_q};
      sack_sync_q  <= {sack_sync_q[0], sleep_core_q};
      iack_sync_q  <= {iack_sync_q[0], init_core_q};
    end
  end

  // ==========================================================
  // software request bits
  logic sleep_ack_q;
  logic init_ack_q;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sleep_request_q <= 1'b0;
      init_request_q  <= 1'b1;
      sleep_ack_q     <= 1'b0;
      init_ack_q      <= 1'b1;
    end else if (mode_q != can_mode_pkg::MODE_POWER_DOWN) begin
      sleep_ack_q <= sack_sync_q[1] & sleep_request_q;
      init_ack_q  <= iack_sync_q[1] & init_request_q;
      if (sleep_request_set_in) begin
        sleep_request_q <= 1'b1;
      end else if (sleep_request_clr_in && sleep_ack_q) begin
        sleep_request_q <= 1'b0;
      end else if (wake_event_out) begin
        sleep_request_q <= 1'b0;
      end
      if (init_request_set_in) begin
        init_request_q <= 1'b1;
      end else if (init_request_clr_in && init_ack_q) begin
        init_request_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // wake-up glitch filter
  logic [9:0] glitch_cnt_q;
  logic       wake_seen;
  always_ff @(posedge clock_in) begin
    if (rst_in || rx_q == `RECESSIVE || !wake_enable_in
        || mode_q != can_mode_pkg::MODE_SLEEP) begin
      glitch_cnt_q <= 10'h000;
    end else if (glitch_cnt_q != 10'(`GLITCH_CYCLES)) begin
      glitch_cnt_q <= glitch_cnt_q + 10'h001;
    end
  end
  assign wake_seen = wake_filter_select_in ? (glitch_cnt_q == 10'(`GLITCH_CYCLES))
                                           : (rx_q != `RECESSIVE);

  // ==========================================================
  // mode state machine
  logic       power_down;
  logic       slept_q;
  logic [9:0] rec_cnt_q;
  logic       woke_q;
  assign power_down = cpu_stop_in | (cpu_wait_in & stop_in_wait_in);
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mode_q         <= can_mode_pkg::MODE_INIT;
      sleep_core_q   <= 1'b0;
      init_core_q    <= 1'b1;
      slept_q        <= 1'b0;
      rec_cnt_q      <= 10'h000;
      wake_event_out <= 1'b0;
      woke_q         <= 1'b0;
    end else begin
      wake_event_out <= 1'b0;
      // stale synchronised sleep request after a bus wake must not re-enter sleep
      if (!sleep_sync_q[1]) begin
        woke_q <= 1'b0;
      end
      if (power_down && mode_q != can_mode_pkg::MODE_POWER_DOWN) begin
        slept_q <= (mode_q == can_mode_pkg::MODE_SLEEP);
        mode_q  <= can_mode_pkg::MODE_POWER_DOWN;
      end else begin
        case (mode_q)
          can_mode_pkg::MODE_NORMAL: begin
            if (init_sync_q[`INIT_CAN_STAGES-1]) begin
              mode_q      <= can_mode_pkg::MODE_INIT;
              init_core_q <= 1'b1;
            end else if (sleep_sync_q[1] && !woke_q) begin
              mode_q <= can_mode_pkg::MODE_SLEEP_PEND;
            end
          end
          can_mode_pkg::MODE_SLEEP_PEND: begin
            if (init_sync_q[`INIT_CAN_STAGES-1]) begin
              mode_q      <= can_mode_pkg::MODE_INIT;
              init_core_q <= 1'b1;
            end else if (!sleep_sync_q[1]) begin
              mode_q <= can_mode_pkg::MODE_NORMAL;
            end else if (!tx_pending_in && !rx_active_in) begin
              mode_q       <= can_mode_pkg::MODE_SLEEP;
              sleep_core_q <= 1'b1;
            end
          end
          can_mode_pkg::MODE_SLEEP: begin
            if (init_sync_q[`INIT_CAN_STAGES-1]) begin
              mode_q      <= can_mode_pkg::MODE_INIT;
              init_core_q <= 1'b1;
            end else if (!sleep_sync_q[1] || (wake_enable_in && wake_seen)) begin
              mode_q         <= can_mode_pkg::MODE_NORMAL;
              sleep_core_q   <= 1'b0;
              wake_event_out <= wake_enable_in & wake_seen;
              woke_q         <= wake_enable_in & wake_seen;
            end
          end
          can_mode_pkg::MODE_INIT: begin
            sleep_core_q <= 1'b0;
            if (!init_sync_q[`INIT_CAN_STAGES-1]) begin
              mode_q      <= can_mode_pkg::MODE_NORMAL;
              init_core_q <= 1'b0;
            end
          end
          can_mode_pkg::MODE_POWER_DOWN: begin
            if (!power_down) begin
              rec_cnt_q <= 10'h000;
              mode_q <= slept_q ? can_mode_pkg::MODE_SLEEP
                                : can_mode_pkg::MODE_RECOVER;
            end
          end
          can_mode_pkg::MODE_RECOVER: begin
            rec_cnt_q <= rec_cnt_q + 10'h001;
            if (rec_cnt_q == 10'(`RECOVERY_CYCLES - 1)) begin
              mode_q       <= init_core_q ? can_mode_pkg::MODE_INIT
                                          : can_mode_pkg::MODE_NORMAL;
              sleep_core_q <= 1'b0;
            end
          end
          default: mode_q <= can_mode_pkg::MODE_INIT;
        endcase
      end
    end
  end

  // ==========================================================
  // bus resynchronisation after wake or init
  logic [7:0] bit_cnt_q;
  logic [3:0] rec_bits_q;
  logic       engine_on;
  assign engine_on = (mode_q == can_mode_pkg::MODE_NORMAL)
                   | (mode_q == can_mode_pkg::MODE_SLEEP_PEND);
  always_ff @(posedge clock_in) begin
    if (rst_in || !engine_on) begin
      bit_cnt_q        <= 8'h00;
      rec_bits_q       <= 4'h0;
      synchronized_out <= 1'b0;
    end else if (rx_q != `RECESSIVE) begin
      bit_cnt_q  <= 8'h00;
      rec_bits_q <= synchronized_out ? rec_bits_q : 4'h0;
    end else if (bit_cnt_q == 8'(`BIT_CYCLES - 1)) begin
      bit_cnt_q <= 8'h00;
      if (rec_bits_q == 4'(`IDLE_BITS - 1)) begin
        synchronized_out <= 1'b1;
      end else begin
        rec_bits_q <= rec_bits_q + 4'h1;
      end
    end else begin
      bit_cnt_q <= bit_cnt_q + 8'h01;
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      bus_tx_pin_out       <= `RECESSIVE;
      engine_rx_out        <= `RECESSIVE;
      engine_run_out       <= 1'b0;
      engine_abort_out     <= 1'b1;
      regs_reset_out       <= 1'b1;
      config_write_en_out  <= 1'b0;
      reg_access_en_out    <= 1'b0;
      clocks_on_out        <= 1'b0;
      deferred_run_out     <= 1'b0;
      busoff_count_run_out <= 1'b0;
      irq_out              <= '0;
    end else begin
      bus_tx_pin_out <= engine_on ? engine_tx_in : `RECESSIVE;
      engine_rx_out  <= (mode_q == can_mode_pkg::MODE_SLEEP && !wake_enable_in)
                        ? `RECESSIVE : rx_q;
      engine_run_out   <= engine_on & synchronized_out;
      engine_abort_out <= (mode_q == can_mode_pkg::MODE_INIT)
                        | (mode_q == can_mode_pkg::MODE_POWER_DOWN);
      regs_reset_out   <= (mode_q == can_mode_pkg::MODE_INIT);
      config_write_en_out <= (mode_q == can_mode_pkg::MODE_INIT) & init_ack_q
                           & config_write_in;
      reg_access_en_out <= (mode_q != can_mode_pkg::MODE_POWER_DOWN);
      clocks_on_out     <= engine_on | (mode_q == can_mode_pkg::MODE_RECOVER);
      deferred_run_out  <= engine_on;
      busoff_count_run_out <= engine_on & bus_off_in;
      irq_out.wake  <= irq_flags_in.wake_irq_flag & irq_enables_in.wake_irq_enable;
      irq_out.error <= (irq_flags_in.status_change_flag
                        & irq_enables_in.status_change_irq_enable)
                     | (irq_flags_in.overrun_flag & irq_enables_in.overrun_irq_enable);
      irq_out.rx    <= irq_flags_in.rx_full_flag & irq_enables_in.rx_full_irq_enable;
      irq_out.tx    <= |(irq_flags_in.tx_empty_flags
                         & irq_enables_in.tx_empty_irq_enables);
    end
  end

  assign sleep_request_out     = sleep_request_q;
  assign sleep_acknowledge_out = sleep_ack_q;
  assign init_request_out      = init_request_q;
  assign init_acknowledge_out  = init_ack_q;

endmodule : can_power_init_mode_ctrl
`default_nettype wire

// >>> tb/can_bus_model.sv
// far-side bus model: wired-and bus level seen at the receive pin
`timescale 1ns/1ns
`default_nettype none
// =====
// bus model
module can_bus_model (
  input  wire logic tx_pin_in,
  input  wire logic dominant_in,
  output logic      bus_level_out
);
  // any node pulling dominant wins, idle bus floats recessive
  assign bus_level_out = tx_pin_in & ~dominant_in;
endmodule : can_bus_model
`default_nettype wire

// >>> tb/can_power_init_mode_ctrl_chk.sv
// assertions on the ports of the can mode controller
`timescale 1ns/1ns
`default_nettype none
// =====
// checker
module can_mode_chk (
  input wire logic                       clock_in,
  input wire logic                       rst_in,
  input wire logic                       init_request_out,
  input wire logic                       init_acknowledge_out,
  input wire logic                       sleep_request_out,
  input wire logic                       sleep_acknowledge_out,
  input wire logic                       bus_tx_pin_out,
  input wire logic                       cpu_stop_in,
  input wire logic                       cpu_wait_in,
  input wire logic                       stop_in_wait_in,
  input wire logic                       clocks_on_out,
  input wire logic                       wake_enable_in,
  input wire logic                       engine_rx_out,
  input wire logic                       wake_event_out,
  input wire can_mode_pkg::irq_flags_s   irq_flags_in,
  input wire can_mode_pkg::irq_enables_s irq_enables_in,
  input wire can_mode_pkg::irq_lines_s   irq_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  wire pd = cpu_stop_in | (cpu_wait_in & stop_in_wait_in);
  property p_init_tx; init_acknowledge_out |-> bus_tx_pin_out; endproperty
  a_init_tx: assert property (p_init_tx) else $error("tx not recessive in init");
  property p_init_hold; init_request_out && !init_acknowledge_out |=> init_request_out;
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("init request cleared early");
  property p_init_delay; $rose(init_request_out) |-> !init_acknowledge_out [*5]; endproperty
  a_init_delay: assert property (p_init_delay) else $error("init ack too fast");
  property p_init_ack; $rose(init_acknowledge_out) |-> init_request_out; endproperty
  a_init_ack: assert property (p_init_ack) else $error("init ack without request");
  property p_sleep_hold; sleep_request_out && !sleep_acknowledge_out |=> sleep_request_out;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep request cleared early");
  property p_pd; pd [*4] |-> !clocks_on_out && bus_tx_pin_out; endproperty
  a_pd: assert property (p_pd) else $error("power-down not entered");
  property p_mask;
    sleep_request_out && sleep_acknowledge_out && !wake_enable_in && !$past(wake_enable_in)
      |-> engine_rx_out && !wake_event_out;
  endproperty
  a_mask: assert property (p_mask) else $error("bus not masked in sleep");
  property p_irq_we;
    1'b1 |=> irq_out.wake == $past(irq_flags_in.wake_irq_flag & irq_enables_in.wake_irq_enable)
      && irq_out.error == $past(|({irq_flags_in.status_change_flag, irq_flags_in.overrun_flag}
      & {irq_enables_in.status_change_irq_enable, irq_enables_in.overrun_irq_enable}));
  endproperty
  a_irq_we: assert property (p_irq_we) else $error("wake or error irq wrong");
  property p_irq_rt;
    1'b1 |=> irq_out.rx == $past(irq_flags_in.rx_full_flag & irq_enables_in.rx_full_irq_enable)
      && irq_out.tx == $past(|(irq_flags_in.tx_empty_flags & irq_enables_in.tx_empty_irq_enables));
  endproperty
  a_irq_rt: assert property (p_irq_rt) else $error("rx or tx irq wrong");
  property p_wake; wake_event_out |=> !wake_event_out; endproperty
  a_wake: assert property (p_wake) else $error("wake pulse too long");
  c_init: cover property ($rose(init_acknowledge_out));
  c_sleep: cover property ($rose(sleep_acknowledge_out));
  c_wake: cover property (wake_event_out);
  c_pd: cover property (pd [*4]);
endmodule : can_mode_chk
bind can_power_init_mode_ctrl can_mode_chk u_chk (.*);
`default_nettype wire

// >>> tb/test_can_power_init_mode_ctrl.sv
// self-checking testbench of the can mode controller
`timescale 1ns/1ns
`default_nettype none
// =====
// bench
module test_can_power_init_mode_ctrl;
  logic clock_in = 1'b0, rst_in = 1'b1, dominant = 1'b0;
  logic sleep_request_set_in = 1'b0, sleep_request_clr_in = 1'b0;
  logic init_request_set_in = 1'b0, init_request_clr_in = 1'b0;
  logic stop_in_wait_in = 1'b0, wake_enable_in = 1'b0, wake_filter_select_in = 1'b0;
  logic cpu_stop_in = 1'b0, cpu_wait_in = 1'b0, engine_tx_in = 1'b1, tx_pending_in = 1'b0;
  logic rx_active_in = 1'b0, bus_off_in = 1'b0, config_write_in = 1'b0;
  can_mode_pkg::irq_flags_s   irq_flags_in = '0;
  can_mode_pkg::irq_enables_s irq_enables_in = '0;
  can_mode_pkg::irq_lines_s   irq_out;
  wire logic bus_rx_pin_in;
  logic sleep_request_out, sleep_acknowledge_out, init_request_out, init_acknowledge_out;
  logic bus_tx_pin_out, engine_rx_out, engine_run_out, engine_abort_out, synchronized_out;
  logic regs_reset_out, config_write_en_out, reg_access_en_out, clocks_on_out;
  logic deferred_run_out, busoff_count_run_out, wake_event_out;
  int error_cnt = 0, samples_checked = 0, wake_cnt = 0;
  always #20 clock_in = ~clock_in;
  always @(posedge clock_in) if (wake_event_out === 1'b1) wake_cnt <= wake_cnt + 1;
  can_power_init_mode_ctrl DUT (.*);
  can_bus_model bus (.tx_pin_in(bus_tx_pin_out), .dominant_in(dominant),
                     .bus_level_out(bus_rx_pin_in));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_irq(input can_mode_pkg::irq_lines_s got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_irq
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask : cyc
  task automatic pulse(input logic init, input logic set);
    if (init) {init_request_set_in, init_request_clr_in} = {set, !set};
    else {sleep_request_set_in, sleep_request_clr_in} = {set, !set};
    cyc(1);
    {init_request_set_in, init_request_clr_in, sleep_request_set_in, sleep_request_clr_in} = '0;
    cyc(1);
  endtask : pulse
  task automatic wait_ack(input logic init, input logic v);
    for (int i = 0; i < 60; i++) begin
      if ((init ? init_acknowledge_out : sleep_acknowledge_out) === v) break;
      cyc(1);
    end
  endtask : wait_ack
  task automatic test_init_cfg;
    chk_bit(init_acknowledge_out, 1'b1);
    chk_bit(bus_tx_pin_out, 1'b1);
    chk_bit(engine_run_out, 1'b0);
    chk_bit(regs_reset_out, 1'b1);
    config_write_in = 1'b1;
    cyc(2);
    chk_bit(config_write_en_out, 1'b1);
    pulse(1'b1, 1'b0);
    wait_ack(1'b1, 1'b0);
    cyc(2);
    chk_bit(init_request_out, 1'b0);
    chk_bit(config_write_en_out, 1'b0);
    config_write_in = 1'b0;
    engine_tx_in = 1'b0;
    cyc(2);
    chk_bit(bus_tx_pin_out, 1'b0);
  endtask : test_init_cfg
  task automatic test_init_refused;
    pulse(1'b1, 1'b1);
    pulse(1'b1, 1'b0);
    chk_bit(init_request_out, 1'b1);
    wait_ack(1'b1, 1'b1);
    chk_bit(init_acknowledge_out, 1'b1);
    chk_bit(bus_tx_pin_out, 1'b1);
    chk_bit(engine_abort_out, 1'b1);
    pulse(1'b1, 1'b0);
    wait_ack(1'b1, 1'b0);
    chk_bit(init_acknowledge_out, 1'b0);
    engine_tx_in = 1'b1;
  endtask : test_init_refused
  task automatic test_sleep;
    {tx_pending_in, bus_off_in} = 2'h3;
    pulse(1'b0, 1'b1);
    cyc(20);
    chk_bit(sleep_acknowledge_out, 1'b0);
    pulse(1'b0, 1'b0);
    chk_bit(sleep_request_out, 1'b1);
    tx_pending_in = 1'b0;
    wait_ack(1'b0, 1'b1);
    chk_bit(sleep_acknowledge_out, 1'b1);
    dominant = 1'b1;
    cyc(20);
    chk_bit(engine_rx_out, 1'b1);
    chk_bit(wake_cnt == 0, 1'b1);
    chk_bit(busoff_count_run_out, 1'b0);
    chk_bit(deferred_run_out, 1'b0);
    {dominant, wake_filter_select_in, wake_enable_in} = 3'h3;
    cyc(3);
    dominant = 1'b1;
    cyc(4);
    dominant = 1'b0;
    cyc(10);
    chk_bit(wake_cnt == 0, 1'b1);
    dominant = 1'b1;
    cyc(30);
    dominant = 1'b0;
    chk_bit(wake_cnt == 1, 1'b1);
    wait_ack(1'b0, 1'b0);
    chk_bit(sleep_request_out, 1'b0);
    cyc(400);
    chk_bit(synchronized_out, 1'b0);
    for (int i = 0; i < 400 && synchronized_out !== 1'b1; i++) cyc(1);
    chk_bit(synchronized_out, 1'b1);
    chk_bit(busoff_count_run_out, 1'b1);
    chk_bit(deferred_run_out, 1'b1);
    bus_off_in = 1'b0;
    wake_filter_select_in = 1'b0;
    pulse(1'b0, 1'b1);
    wait_ack(1'b0, 1'b1);
    dominant = 1'b1;
    cyc(8);
    dominant = 1'b0;
    chk_bit(wake_cnt == 2, 1'b1);
    wait_ack(1'b0, 1'b0);
  endtask : test_sleep
  task automatic test_pd;
    {engine_tx_in, cpu_wait_in} = 2'h1;
    cyc(6);
    chk_bit(clocks_on_out, 1'b1);
    stop_in_wait_in = 1'b1;
    cyc(6);
    chk_bit(clocks_on_out, 1'b0);
    chk_bit(reg_access_en_out, 1'b0);
    chk_bit(bus_tx_pin_out, 1'b1);
    chk_bit(engine_abort_out, 1'b1);
    pulse(1'b1, 1'b1);
    chk_bit(init_request_out, 1'b0);
    {engine_tx_in, cpu_wait_in} = 2'h2;
    cyc(4);
    chk_bit(engine_run_out, 1'b0);
    for (int i = 0; i < 700 && engine_run_out !== 1'b1; i++) cyc(1);
    chk_bit(engine_run_out, 1'b1);
    cpu_stop_in = 1'b1;
    cyc(6);
    chk_bit(clocks_on_out, 1'b0);
    cpu_stop_in = 1'b0;
  endtask : test_pd
  task automatic test_irq;
    for (int i = 0; i < 7; i++) begin
      irq_flags_in = can_mode_pkg::irq_flags_s'(7'h01 << i);
      irq_enables_in = can_mode_pkg::irq_enables_s'(7'h01 << i);
      cyc(2);
      chk_irq(irq_out, {i == 6, i == 5 || i == 4, i == 3, i < 3});
      irq_enables_in = can_mode_pkg::irq_enables_s'(~(7'h01 << i));
      cyc(2);
      chk_irq(irq_out, 4'h0);
    end
    irq_flags_in = '0;
  endtask : test_irq
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    cyc(3);
    rst_in = 1'b0;
    cyc(2);
    test_init_cfg();
    test_irq();
    test_init_refused();
    test_sleep();
    test_pd();
    report_and_stop();
  end
endmodule : test_can_power_init_mode_ctrl
`default_nettype wire
